// ### rtl/astc_ctrl.sv
// Purpose: start, trigger, reference and channel select of the converter
// Assumes: trigger and capture inputs synchronous to clk
// Notes:   registers reached over apb, always ready, no wait states
`timescale 1ns/100ps
module astc_ctrl
    import astc_pkg::*;
#(
    parameter int TRIG_W = 1
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         clk_en,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [astc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic [31:0]                       prdata,
    output logic                              pready,
    output logic                              pslverr,
    // hardware start sources
    input  wire logic                         external_trigger_in,
    input  wire logic                         timer_four_capture_event,
    input  wire logic                         timer_five_capture_event,
    // converter side
    input  wire logic                         converting,
    input  wire logic                         idle_mode,
    output logic                              normal_start_req,
    output logic                              priority_start_req,
    output logic [astc_pkg::CH_W-1:0]         normal_analog_input_ch,
    output logic [astc_pkg::CH_W-1:0]         priority_analog_input_ch,
    output logic                              ref_power_on,
    output logic                              ref_current_on,
    output logic                              converter_run
);
    import astc_pkg::*;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // one trigger line only; a wider bus would need a source select
    if (TRIG_W != 1) begin : g_bad_trig_w
        $error("astc_ctrl: only one trigger line is supported");
    end

    // both channel fields must sit in the low byte, apart
    if (PRIO_CH_LSB + CH_W > 8) begin : g_bad_prio_ch
        $error("astc_ctrl: priority channel field leaves the low byte");
    end
    if (NORMAL_CH_LSB + CH_W > PRIO_CH_LSB) begin : g_bad_normal_ch
        $error("astc_ctrl: channel fields overlap");
    end
    // four-bit codes are what maps onto inputs 0 to 14
    if (CH_W != 4) begin : g_bad_ch_w
        $error("astc_ctrl: channel codes must be four bits wide");
    end

    // config and command bits, all but NORMAL_HW_EN_BIT, are checked to ride on byte lane zero
    if (REF_PWR_BIT > 7 || IDLE_RUN_BIT > 7) begin : g_bad_run_bits
        $error("astc_ctrl: reference bits leave the low byte");
    end
    if (REF_CUR_BIT > 7 || PRIO_HW_SRC_BIT > 7) begin : g_bad_src_bits
        $error("astc_ctrl: source bits leave the low byte");
    end
    if (PRIO_HW_EN_BIT > 7 || NORMAL_HW_SRC_BIT > 7) begin : g_bad_en_bits
        $error("astc_ctrl: enable bits leave the low byte");
    end
    if (PRIORITY_START_BIT > 7 || NORMAL_START_BIT > 7) begin : g_bad_cmd
        $error("astc_ctrl: command bits leave the low byte");
    end

    // a reset value outside the mask could never be written back
    if ((REF_TRIG_RESET & ~REF_TRIG_MASK) != 8'h00) begin : g_bad_rst
        $error("astc_ctrl: reference reset value sets a reserved bit");
    end

    // the three offsets must decode in the address width given
    if (ADDR_W < 4) begin : g_bad_addr_w
        $error("astc_ctrl: address too narrow for the register map");
    end

    // ****************************************************************
    // apb decode
    // ****************************************************************
    // bus decode
    logic        wr_en;
    logic        rd_en;
    logic        lane0_wr;
    logic        wr_start;
    logic        wr_ref;
    logic        wr_chan;
    logic        hit_start;
    logic        hit_ref;
    logic        hit_chan;
    logic        mapped;
    logic [31:0] rd_word;

    // config state
    logic [7:0]  ref_trig;
    logic [7:0]  next_ref_trig;
    logic [7:0]  chan_sel;
    logic [7:0]  next_chan_sel;

    // start pulses
    logic        next_normal_req;
    logic        next_priority_req;
    logic        sw_normal;
    logic        sw_priority;
    logic        hw_normal_ev;
    logic        hw_priority_ev;
    logic        trig_claimed;

    // bus response
    logic [31:0] next_prdata;
    logic        next_pslverr;

    assign hit_start = (paddr == START_CMD_OFS);
    assign hit_ref   = (paddr == REF_TRIG_OFS);
    assign hit_chan  = (paddr == CHAN_SEL_OFS);
    assign mapped    = hit_start | hit_ref | hit_chan;
    assign wr_en     = psel & penable & pwrite & clk_en;

    // ****************************************************************
    // write strobes
    // ****************************************************************
    // only lane zero carries bits; writes without it change nothing
    assign lane0_wr  = wr_en & pstrb[0];
    assign wr_start  = lane0_wr & hit_start;
    assign wr_ref    = lane0_wr & hit_ref;
    assign wr_chan   = lane0_wr & hit_chan;

    assign rd_en     = psel & ~penable & ~pwrite;
    // zero wait states keep the master simple; data comes from a flop
    assign pready    = 1'b1;

    // ****************************************************************
    // request logic
    // ****************************************************************
    // only low byte holds commands, so strobe lane zero gates them
    assign sw_normal   = wr_start
                         & pwdata[NORMAL_START_BIT];
    assign sw_priority = wr_start
                         & pwdata[PRIORITY_START_BIT];

    // priority class claims the trigger only while its hw start is armed with the trigger line as its source
    assign trig_claimed = ref_trig[PRIO_HW_EN_BIT]
                          & ~ref_trig[PRIO_HW_SRC_BIT];

    // priority class: enable gates, source bit picks the line
    always_comb begin
        hw_priority_ev = 1'b0;
        if (ref_trig[PRIO_HW_EN_BIT]) begin
            if (ref_trig[PRIO_HW_SRC_BIT]) begin
                hw_priority_ev = timer_four_capture_event;
            end else begin
                hw_priority_ev = external_trigger_in;
            end
        end
    end

    // normal class: loses the shared trigger to the priority class
    always_comb begin
        hw_normal_ev = 1'b0;
        if (ref_trig[NORMAL_HW_EN_BIT]) begin
            if (ref_trig[NORMAL_HW_SRC_BIT]) begin
                hw_normal_ev = timer_five_capture_event;
            end else begin
                // shared trigger goes to the priority class only while that class claims it
                hw_normal_ev = external_trigger_in & ~trig_claimed;
            end
        end
    end

    // a command and an event in one cycle still give a single pulse
    always_comb begin
        next_normal_req   = sw_normal | (clk_en & hw_normal_ev);
        next_priority_req = sw_priority | (clk_en & hw_priority_ev);
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_comb begin
        next_ref_trig = ref_trig;
        next_chan_sel = chan_sel;
        // unused bits are masked on the way in
        if (wr_ref) begin
            next_ref_trig = pwdata[7:0] & REF_TRIG_MASK;
        end
        if (wr_chan) begin
            next_chan_sel = pwdata[7:0];
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    // start register has no readable bits
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_ref) begin
            rd_word[7:0] = ref_trig;
        end
        if (hit_chan) begin
            rd_word[7:0] = chan_sel;
        end
    end

    // data captured in setup so it stands through the access phase
    always_comb begin
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (rd_en) begin
            next_prdata  = rd_word;
            next_pslverr = ~mapped;
        end else if (psel && !penable) begin
            next_pslverr = ~mapped;
        end
    end

    // ****************************************************************
    // config state
    // ****************************************************************
    // clk_en low holds both config registers
    always_ff @(posedge clk) begin
        if (reset) begin
            ref_trig <= REF_TRIG_RESET;
            chan_sel <= CHAN_SEL_RESET;
        end else if (clk_en) begin
            ref_trig <= next_ref_trig;
            chan_sel <= next_chan_sel;
        end
    end

    // ****************************************************************
    // start pulses
    // ****************************************************************
    // pulses drop to zero while frozen so none is stretched
    always_ff @(posedge clk) begin
        if (reset) begin
            normal_start_req   <= 1'b0;
            priority_start_req <= 1'b0;
        end else if (clk_en) begin
            normal_start_req   <= next_normal_req;
            priority_start_req <= next_priority_req;
        end else begin
            normal_start_req   <= 1'b0;
            priority_start_req <= 1'b0;
        end
    end

    // ****************************************************************
    // bus response
    // ****************************************************************
    // read data stands from setup until the next read setup
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ****************************************************************
    // outputs to the converter
    // ****************************************************************
    // code 1111 is forbidden; passed through unchanged, converter decides
    assign priority_analog_input_ch =
        chan_sel[PRIO_CH_LSB +: CH_W];
    assign normal_analog_input_ch   =
        chan_sel[NORMAL_CH_LSB +: CH_W];

    // reference supply follows its bit directly
    assign ref_power_on   = ref_trig[REF_PWR_BIT];

    // ladder current is cut while reset is held, whatever the bit says
    assign ref_current_on = ~reset
                            & (ref_trig[REF_CUR_BIT] | converting);

    // idle only halts the converter when the run bit is clear
    assign converter_run  = ~idle_mode | ref_trig[IDLE_RUN_BIT];

endmodule // astc_ctrl

// ### rtl/astc_pkg.sv
// Purpose: constants for the converter start, trigger and channel control
// Assumes: apb slave with 32-bit data, one word per register
// Notes:   offsets are byte addresses within the block
package astc_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [11:0] START_CMD_OFS   = 12'h000;
    localparam logic [11:0] REF_TRIG_OFS    = 12'h004;
    localparam logic [11:0] CHAN_SEL_OFS    = 12'h008;
    localparam int          ADDR_W          = 12;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int NORMAL_START_BIT   = 0;
    localparam int PRIORITY_START_BIT = 1;
    localparam int NORMAL_HW_EN_BIT   = 0;
    localparam int NORMAL_HW_SRC_BIT  = 1;
    localparam int PRIO_HW_EN_BIT     = 2;
    localparam int PRIO_HW_SRC_BIT    = 3;
    localparam int REF_CUR_BIT        = 5;
    localparam int IDLE_RUN_BIT       = 6;
    localparam int REF_PWR_BIT        = 7;
    localparam int NORMAL_CH_LSB      = 0;
    localparam int PRIO_CH_LSB        = 4;
    localparam int CH_W               = 4;
    // ****************************************************************
    // reset values and masks
    // ****************************************************************
    localparam logic [7:0]  REF_TRIG_RESET  = 8'h00;
    localparam logic [7:0]  CHAN_SEL_RESET  = 8'h00;
    localparam logic [7:0]  REF_TRIG_MASK   = 8'hEF;
    localparam logic [3:0]  CH_ILLEGAL      = 4'hF;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ          = 20;
    localparam int REF_SETTLE_US    = 3;
    localparam int REF_SETTLE_CYC   = REF_SETTLE_US * CLK_MHZ;
endpackage

// ### tb/astc_ctrl_asserts.sv
// Purpose: port assertions for the converter start control
// Assumes: one clock, sync reset
// Notes:   bound from the bench top
`timescale 1ns/100ps
module astc_ctrl_asserts
    import astc_pkg::*;
(
    // apb side
    input wire logic        clk, reset, clk_en, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // start sources and converter side
    input wire logic        external_trigger_in, converting, idle_mode,
    input wire logic        timer_four_capture_event,
    input wire logic        timer_five_capture_event,
    input wire logic        normal_start_req, priority_start_req,
    input wire logic [3:0]  normal_analog_input_ch,
    input wire logic [3:0]  priority_analog_input_ch,
    input wire logic        ref_current_on, converter_run
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire wr  = psel & penable & pwrite & clk_en;
    wire gon = wr & (paddr == START_CMD_OFS) & pwdata[0];
    wire gop = wr & (paddr == START_CMD_OFS) & pwdata[1];
    wire nsr = gon | external_trigger_in | timer_five_capture_event;
    wire psr = gop | external_trigger_in | timer_four_capture_event;
    wire bad = !(paddr inside {START_CMD_OFS, REF_TRIG_OFS, CHAN_SEL_OFS});
    wire chw = wr & (paddr == CHAN_SEL_OFS);
    property p_nstart; gon |=> normal_start_req; endproperty
    a_nstart: assert property (p_nstart) else $error("no normal pulse");
    property p_pstart; gop |=> priority_start_req; endproperty
    a_pstart: assert property (p_pstart) else $error("no prio pulse");
    property p_ncause; normal_start_req |-> $past(nsr); endproperty
    a_ncause: assert property (p_ncause) else $error("stray normal");
    property p_pcause; priority_start_req |-> $past(psr); endproperty
    a_pcause: assert property (p_pcause) else $error("stray prio");
    property p_refcur; converting |-> ref_current_on; endproperty
    a_refcur: assert property (p_refcur) else $error("ladder off");
    property p_run; !idle_mode |-> converter_run; endproperty
    a_run: assert property (p_run) else $error("converter halted");
    property p_err; psel && !penable && clk_en && bad |=> pslverr; endproperty
    a_err: assert property (p_err) else $error("no slave error");
    property p_chan;
        $changed({priority_analog_input_ch, normal_analog_input_ch})
            |-> $past(chw) || $past(reset);
    endproperty
    a_chan: assert property (p_chan) else $error("channel moved");
    c_both: cover property (normal_start_req && priority_start_req);
    c_err: cover property (pslverr);
    c_conv: cover property (converting && !idle_mode);
endmodule // astc_ctrl_asserts

// ### tb/astc_far.sv
// Purpose: far side model, start sources and a busy converter
// Assumes: the bench holds each fire bit for one cycle
// Notes:   busy for four cycles after any start pulse
`timescale 1ns/100ps
module astc_far (
    // clock, reset and bench requests
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [2:0] fire,
    input  wire logic       start,
    // events and busy
    output logic            external_trigger_in,
    output logic            timer_four_capture_event,
    output logic            timer_five_capture_event,
    output logic            converting
);
    logic [2:0] busy;
    always_ff @(posedge clk) begin
        {timer_five_capture_event, timer_four_capture_event,
         external_trigger_in} <= reset ? 3'h0 : fire;
        busy <= reset ? 3'h0 : start ? 3'h4 : busy - 3'(busy != 3'h0);
    end
    assign converting = busy != 3'h0;
endmodule // astc_far

// ### tb/tb_adc_start_trigger_channel_ctrl.sv
// Purpose: self-checking bench for the converter start control
// Assumes: clk_en and pstrb on except in the freeze and lane cases
// Notes:   trigger sweep walks every low config nibble and source
`timescale 1ns/100ps
module tb_adc_start_trigger_channel_ctrl;
    import astc_pkg::*;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic clk_en = 1, idle_mode = 0, pready, pslverr, converting;
    logic [3:0]  pstrb = 4'hF, normal_analog_input_ch, priority_analog_input_ch;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, v;
    logic [2:0]  fire = 0;
    logic external_trigger_in, timer_four_capture_event, ref_power_on;
    logic timer_five_capture_event, normal_start_req, priority_start_req;
    logic ref_current_on, converter_run;
    int   fail_count = 0, comparisons = 0;
    always #25 clk = ~clk;
    astc_ctrl i_dut (.*);
    astc_far i_far (.start(normal_start_req | priority_start_req), .*);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        #1;
    endtask
    function automatic logic [1:0] hw_exp(input logic [3:0] c, input int s);
        logic p, n;
        p = c[2] & (c[3] ? s == 1 : s == 0);
        n = c[0] & (c[1] ? s == 2 : s == 0) & !(s == 0 & c[2] & !c[3]);
        return {p, n};
    endfunction
    task automatic tally_and_finish;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h1FE22C10));
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (int a = 0; a < 12; a += 4) begin
            apb(1'b0, a[11:0], 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b1, REF_TRIG_OFS, 32'h80);
        repeat (REF_SETTLE_CYC) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            apb(1'b1, START_CMD_OFS, {v[31:2], 2'(i)});
            chk({priority_start_req, normal_start_req}, i);
            @(posedge clk);
            #1 chk({priority_start_req, normal_start_req}, 0);
        end
        for (int c = 0; c < 16; c++)
            for (int s = 0; s < 3; s++) begin
                v = $urandom;
                v[7] = 1'b1;
                @(posedge clk) idle_mode <= v[9];
                apb(1'b1, REF_TRIG_OFS, {v[31:4], 4'(c)});
                apb(1'b0, REF_TRIG_OFS, 32'h0);
                chk(rd, {24'h0, v[7:5], 1'b0, 4'(c)});
                chk({ref_power_on, converter_run, ref_current_on},
                    {v[7], !idle_mode | v[6], v[5] | converting});
                @(posedge clk) fire <= 3'b001 << s;
                @(posedge clk) fire <= 3'h0;
                @(posedge clk);
                #1 chk({priority_start_req, normal_start_req}, hw_exp(4'(c), s));
            end
        for (int i = 0; i < 15; i++) begin
            v = $urandom;
            v[7:0] = {4'(14 - i), 4'(i)};
            apb(1'b1, CHAN_SEL_OFS, v);
            chk({priority_analog_input_ch, normal_analog_input_ch}, v[7:0]);
            apb(1'b0, CHAN_SEL_OFS, 32'h0);
            chk(rd, v[7:0]);
        end
        apb(1'b1, 12'h00C, 32'hFF);
        apb(1'b0, 12'h00C, 32'h0);
        chk(err, 1);
        chk(rd, 32'h0);
        chk({priority_analog_input_ch, normal_analog_input_ch}, 8'h0E);
        @(posedge clk) pstrb <= 4'hE;
        apb(1'b1, CHAN_SEL_OFS, 32'h77);
        chk({priority_analog_input_ch, normal_analog_input_ch}, 8'h0E);
        @(posedge clk) {pstrb, clk_en} <= {4'hF, 1'b0};
        apb(1'b1, CHAN_SEL_OFS, 32'h33);
        chk({priority_analog_input_ch, normal_analog_input_ch}, 8'h0E);
        @(posedge clk) clk_en <= 1'b1;
        apb(1'b1, REF_TRIG_OFS, 32'h0);
        chk(ref_power_on, 0);
        @(posedge clk) reset <= 1'b1;
        @(posedge clk) reset <= 1'b0;
        #1 chk({priority_analog_input_ch, normal_analog_input_ch}, 0);
        apb(1'b0, CHAN_SEL_OFS, 32'h0);
        chk(rd, 32'h0);
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
endmodule // tb_adc_start_trigger_channel_ctrl
bind astc_ctrl astc_ctrl_asserts i_chk (.*);
